/* cme_consts.vh */
`ifndef CME_CONSTS_VH
`define CME_CONSTS_VH
// Opcodes
`define CME_OP_PU     8'h01
`define CME_OP_STOP   8'h02
`define CME_OP_RESET  8'h03
`define CME_OP_IRQC   8'h04
`define CME_OP_STAT   8'h05
`define CME_OP_SLEEP  8'h07
`define CME_OP_PLAY   8'h40
`define CME_OP_CAP    8'h41
`define CME_OP_ERASE  8'h42
`define CME_OP_WIPE   8'h43
`define CME_OP_SKIP   8'h48
`define CME_OP_CHK    8'h49
// Memory rows
`define CME_ROW_ZERO  11'h000
`define CME_ROW_FIRST 11'h010
`define CME_ROW_LAST  11'h7FF
`define CME_ROW_ONE   11'h001
// Row time in clock cycles
`define CME_ROW_CYC   8'h20
// Status byte 0 fields
`define CME_S0_BAD    0
`define CME_S0_FULL   1
`define CME_S0_PU     2
`define CME_S0_EOM    3
`define CME_S0_IRQ    4
// Status byte 1 fields, activity bits low while active
`define CME_S1_RDY    0
`define CME_S1_ERASE  1
`define CME_S1_PLAY   2
`define CME_S1_CAP    3
// Register word indices, byte address bits 3:2
`define CME_A_CMD     2'h0
`define CME_A_STAT    2'h1
`define CME_A_PPTR    2'h2
`define CME_A_CPTR    2'h3
`endif

/* cme_sync.v */
module cme_sync #(
   parameter       W  = 1,
   parameter [W-1:0] RV = {W{1'b0}}
) (
   // Clock and reset
   input  wire         clk_i,
   input  wire         rst_i,
   // Data
   input  wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);
   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;

   always @(posedge clk_i) begin
      if (rst_i) begin
         s1_r <= RV;
         s2_r <= RV;
      end else begin
         s1_r <= d_i;
         s2_r <= s1_r;
      end
   end

   assign q_o = s2_r;
endmodule

/* cme_spi_frame.v */
module cme_spi_frame (
   // Clock and reset
   input  wire       clk_i,
   input  wire       rst_i,
   // Synchronised link pins
   input  wire       sclk_i,
   input  wire       mosi_i,
   input  wire       ss_n_i,
   // Status byte to return
   input  wire [7:0] status_i,
   // Link output
   output reg        miso_o,
   output wire       miso_oe_o,
   // Received frame
   output reg        frm_v_o,
   output reg  [7:0] frm_op_o
);
   reg        sclk_r;
   reg        ss_r;
   reg [4:0]  bitc_r;
   reg [15:0] sh_in_r;
   reg [7:0]  sh_out_r;

   assign miso_oe_o = ~ss_r;

   always @(posedge clk_i) begin
      if (rst_i) begin
         sclk_r   <= 1'b0;
         ss_r     <= 1'b1;
         bitc_r   <= 5'h00;
         sh_in_r  <= 16'h0000;
         sh_out_r <= 8'h00;
         miso_o   <= 1'b0;
         frm_v_o  <= 1'b0;
         frm_op_o <= 8'h00;
      end else begin
         sclk_r  <= sclk_i;
         ss_r    <= ss_n_i;
         frm_v_o <= 1'b0;
         if (ss_r && !ss_n_i) begin
            bitc_r   <= 5'h00;
            sh_out_r <= status_i;
            miso_o   <= status_i[7];
         end else if (!ss_n_i) begin
            if (sclk_i && !sclk_r) begin
               sh_in_r <= {sh_in_r[14:0], mosi_i};
               if (bitc_r != 5'h1F)
                  bitc_r <= bitc_r + 5'h01;
            end else if (!sclk_i && sclk_r) begin
               sh_out_r <= {sh_out_r[6:0], 1'b0};
               miso_o   <= sh_out_r[6];
            end
         end else if (!ss_r) begin
            // Frame end: exactly opcode plus zero byte
            if (bitc_r == 5'h10 && sh_in_r[7:0] == 8'h00) begin // RQ21
               frm_v_o  <= 1'b1;
               frm_op_o <= sh_in_r[15:8];
            end
         end
      end
   end
endmodule

/* cme_exec.v */
// Function
// RQ1: Playback starts at playback pointer, ends at end marker or stop.
// RQ2: While playing only stop, reset, irq clear, status, sleep; else flag.
// RQ3: Ready and playing bit stay low for the whole playback.
// RQ4: Capture starts at capture pointer, ends on stop or full memory.
// RQ5: While capturing only stop, reset, irq clear, status, sleep; else flag.
// RQ6: Ready and capture bit stay low for the whole capture.
// RQ7: Erase current message row by row only if first or last message.
// RQ8: During erase stop is refused; others besides the priority set flag.
// RQ9: Erase of a middle message sets the flag and erases nothing.
// RQ10: Ready and erase bit stay low during single erase.
// RQ11: Wipe clears all rows except the sound effect rows.
// RQ12: Ready and erase bit stay low until wipe finishes.
// RQ13: Skip moves playback pointer to the next message start.
// RQ14: Skip runs only when idle, never during playback.
// RQ15: Host stops, skips, then plays again to skip while playing.
// RQ16: Layout check only when powered up and idle.
// RQ17: Failed layout check sets the bad command flag.
// RQ18: Good check sets pointers to last message and first free row.
// RQ19: Every circular command first checks layout; mismatch flags, skips.
// RQ20: Irq clear clears irq and end marker flags, state unchanged.
// RQ21: Frames are opcode then zero byte; status byte returned first.
// RQ22: Command completion sets irq flag and drives interrupt output.
`include "cme_consts.vh"
module cme_exec (
   // Clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // Wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // Command link
   input  wire        sclk_i,
   input  wire        mosi_i,
   input  wire        ss_n_i,
   output wire        miso_o,
   output wire        miso_oe_o,
   // Status pins
   output wire        int_n_o,
   output wire        ready_o
);
   localparam [3:0] ST_IDLE  = 4'h0;
   localparam [3:0] ST_SCAN  = 4'h1;
   localparam [3:0] ST_DEC   = 4'h2;
   localparam [3:0] ST_PLAY  = 4'h3;
   localparam [3:0] ST_CAP   = 4'h4;
   localparam [3:0] ST_ERASE = 4'h5;
   localparam [3:0] ST_WIPE  = 4'h6;
   localparam [3:0] ST_SKIP  = 4'h7;

   reg        used_m [0:2047];
   reg        eom_m  [0:2047];

   reg [3:0]  st_r;
   reg [7:0]  op_r;
   reg [7:0]  last_op_r;
   reg [10:0] row_r;
   reg [7:0]  tmr_r;
   reg [10:0] play_r;
   reg [10:0] cap_r;
   reg [10:0] cap_start_r;
   reg [10:0] cur_start_r;
   reg [10:0] last_start_r;
   reg [10:0] first_start_r;
   reg [10:0] free_r;
   reg [1:0]  rises_r;
   reg        prev_used_r;
   reg        prev_eom_r;
   reg        wrote_r;
   reg        init_r;
   reg        done_r;
   reg        sleep_pend_r;
   reg        bad_r;
   reg        full_r;
   reg        pu_r;
   reg        eom_r;
   reg        irq_r;

   wire [2:0] pin_q;
   wire       spi_v;
   wire [7:0] spi_op;
   wire       wb_req;
   wire       wb_map;
   wire       wb_cmd_v;
   wire       cmd_v;
   wire [7:0] op;
   wire       busy;
   wire       prio;
   wire       circ;
   wire       stop_ok;
   wire       bad_cmd;
   wire       start;
   wire       stop_now;
   wire       rst_cmd;
   wire       tick;
   wire [10:0] row_inc;
   wire [10:0] row_nx;
   wire       cur_u;
   wire       cur_e;
   wire       nx_u;
   wire       is_start;
   wire [7:0] sr0;
   wire [7:0] sr1;

   cme_sync #(.W(3), .RV(3'b100)) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({ss_n_i, mosi_i, sclk_i}),
      .q_o   (pin_q)
   );

   cme_spi_frame u_frame (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .sclk_i    (pin_q[0]),
      .mosi_i    (pin_q[1]),
      .ss_n_i    (pin_q[2]),
      .status_i  (sr0),
      .miso_o    (miso_o),
      .miso_oe_o (miso_oe_o),
      .frm_v_o   (spi_v),
      .frm_op_o  (spi_op)
   );

   // Status bytes
   assign sr0 = {3'b000, irq_r, eom_r, pu_r, full_r, bad_r};
   assign busy = (st_r != ST_IDLE);
   assign sr1 = {4'h0,
                 ~(busy && op_r == `CME_OP_CAP), // RQ6
                 ~(busy && op_r == `CME_OP_PLAY), // RQ3
                 ~(busy && (op_r == `CME_OP_ERASE ||
                            op_r == `CME_OP_WIPE || init_r)), // RQ10 RQ12
                 ~busy};
   assign ready_o = ~busy;
   assign int_n_o = ~irq_r; // RQ22

   // Wishbone decode
   assign wb_req   = wb_cyc_i & wb_stb_i;
   assign wb_map   = (wb_adr_i[7:4] == 4'h0);
   assign wb_cmd_v = wb_req & wb_ack_o & wb_we_i & wb_sel_i[0] & wb_map &
                     (wb_adr_i[3:2] == `CME_A_CMD);

   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_req & ~wb_ack_o;
         if (wb_req && !wb_ack_o) begin
            if (!wb_map)
               wb_dat_o <= 32'h00000000;
            else case (wb_adr_i[3:2])
               `CME_A_CMD:  wb_dat_o <= {24'h000000, last_op_r};
               `CME_A_STAT: wb_dat_o <= {16'h0000, sr1, sr0};
               `CME_A_PPTR: wb_dat_o <= {21'h000000, play_r};
               default:     wb_dat_o <= {21'h000000, cap_r};
            endcase
         end
      end
   end

   // Command decode, link frame wins a same-cycle clash
   assign cmd_v = spi_v | wb_cmd_v;
   assign op    = spi_v ? spi_op : wb_dat_i[7:0];
   assign prio  = (op == `CME_OP_STOP)  || (op == `CME_OP_RESET) ||
                  (op == `CME_OP_IRQC)  || (op == `CME_OP_STAT)  ||
                  (op == `CME_OP_SLEEP);
   assign circ  = (op == `CME_OP_PLAY)  || (op == `CME_OP_CAP)   ||
                  (op == `CME_OP_ERASE) || (op == `CME_OP_WIPE)  ||
                  (op == `CME_OP_SKIP)  || (op == `CME_OP_CHK);
   assign stop_ok = (st_r == ST_PLAY) || (st_r == ST_CAP);
   assign bad_cmd = cmd_v & (busy ?
                    ~(prio & ~((op == `CME_OP_STOP) & ~stop_ok)) : // RQ2 RQ5 RQ8
                    ((op == `CME_OP_CHK) & ~pu_r)); // RQ16
   assign start    = cmd_v & ~busy & circ & ~bad_cmd; // RQ14
   assign stop_now = cmd_v & (op == `CME_OP_STOP) & stop_ok;
   assign rst_cmd  = cmd_v & (op == `CME_OP_RESET) & ~init_r;
   assign tick     = (tmr_r == `CME_ROW_CYC - 8'h01);

   // Layout scan helpers
   assign row_inc  = row_r + `CME_ROW_ONE;
   assign row_nx   = (row_r == `CME_ROW_LAST) ? `CME_ROW_FIRST : row_inc;
   assign cur_u    = used_m[row_r];
   assign cur_e    = eom_m[row_r];
   assign nx_u     = used_m[row_nx];
   assign is_start = cur_u & (prev_eom_r | ~prev_used_r);

   always @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= ST_WIPE;
         init_r <= 1'b1;
         op_r <= 8'h00;
         last_op_r <= 8'h00;
         row_r <= `CME_ROW_ZERO;
         tmr_r <= 8'h00;
         play_r <= `CME_ROW_FIRST;
         cap_r <= `CME_ROW_FIRST;
         cap_start_r <= `CME_ROW_FIRST;
         cur_start_r <= `CME_ROW_FIRST;
         last_start_r <= `CME_ROW_FIRST;
         first_start_r <= `CME_ROW_FIRST;
         free_r <= `CME_ROW_FIRST;
         rises_r <= 2'h0;
         prev_used_r <= 1'b0;
         prev_eom_r <= 1'b0;
         wrote_r <= 1'b0;
         done_r <= 1'b0;
         sleep_pend_r <= 1'b0;
         bad_r <= 1'b0;
         full_r <= 1'b0;
         pu_r <= 1'b0;
         eom_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         tmr_r <= tick ? 8'h00 : tmr_r + 8'h01;
         // Clears first so a same-cycle set below wins
         if (cmd_v && op == `CME_OP_IRQC) begin
            irq_r <= 1'b0; // RQ20
            eom_r <= 1'b0; // RQ20
         end
         if (cmd_v)
            last_op_r <= op;
         if (cmd_v && !busy && op == `CME_OP_PU)
            pu_r <= 1'b1;
         if (cmd_v && op == `CME_OP_SLEEP) begin
            if (busy)
               sleep_pend_r <= 1'b1;
            else begin
               pu_r <= 1'b0;
               irq_r <= 1'b1;
            end
         end
         if (done_r) begin
            irq_r <= 1'b1; // RQ22
            if (sleep_pend_r) begin
               pu_r <= 1'b0;
               sleep_pend_r <= 1'b0;
            end
         end
         if (start)
            bad_r <= 1'b0;
         if (bad_cmd)
            bad_r <= 1'b1; // RQ2 RQ5 RQ8
         if (rst_cmd) begin
            st_r <= ST_IDLE;
            irq_r <= 1'b0;
            eom_r <= 1'b0;
            bad_r <= 1'b0;
            pu_r <= 1'b0;
            sleep_pend_r <= 1'b0;
         end else case (st_r)
            ST_IDLE: begin
               if (start) begin
                  // Layout verified before any circular command
                  op_r <= op; // RQ19
                  st_r <= ST_SCAN;
                  row_r <= `CME_ROW_FIRST;
                  prev_used_r <= used_m[`CME_ROW_LAST];
                  prev_eom_r <= eom_m[`CME_ROW_LAST];
                  rises_r <= 2'h0;
                  cur_start_r <= `CME_ROW_FIRST;
                  last_start_r <= `CME_ROW_FIRST;
                  first_start_r <= `CME_ROW_FIRST;
                  free_r <= `CME_ROW_FIRST;
               end
            end
            ST_SCAN: begin
               if (cur_u && !prev_used_r && rises_r != 2'h2) begin
                  rises_r <= rises_r + 2'h1;
                  first_start_r <= row_r;
               end
               if (is_start)
                  cur_start_r <= row_r;
               if (cur_u && cur_e && !nx_u) begin
                  last_start_r <= is_start ? row_r : cur_start_r;
                  free_r <= row_nx;
               end
               prev_used_r <= cur_u;
               prev_eom_r <= cur_e;
               row_r <= row_nx;
               if (row_r == `CME_ROW_LAST)
                  st_r <= ST_DEC;
            end
            ST_DEC: begin
               tmr_r <= 8'h00;
               wrote_r <= 1'b0;
               st_r <= ST_IDLE;
               if (rises_r > 2'h1) begin
                  bad_r <= 1'b1; // RQ17 RQ19
                  done_r <= 1'b1;
               end else case (op_r)
                  `CME_OP_CHK: begin
                     play_r <= last_start_r; // RQ18
                     cap_r <= free_r; // RQ18
                     done_r <= 1'b1;
                  end
                  `CME_OP_PLAY: begin
                     row_r <= play_r; // RQ1
                     st_r <= ST_PLAY;
                  end
                  `CME_OP_CAP: begin
                     row_r <= cap_r; // RQ4
                     cap_start_r <= cap_r;
                     st_r <= ST_CAP;
                  end
                  `CME_OP_ERASE: begin
                     if (play_r == first_start_r ||
                         play_r == last_start_r) begin // RQ7
                        row_r <= play_r;
                        st_r <= ST_ERASE;
                     end else begin
                        bad_r <= 1'b1; // RQ9
                        done_r <= 1'b1;
                     end
                  end
                  `CME_OP_WIPE: begin
                     row_r <= `CME_ROW_FIRST; // RQ11
                     st_r <= ST_WIPE;
                  end
                  default: begin
                     row_r <= play_r;
                     st_r <= ST_SKIP;
                  end
               endcase
            end
            ST_PLAY: begin
               if (stop_now) begin
                  st_r <= ST_IDLE; // RQ1
                  done_r <= 1'b1;
               end else if (tick) begin
                  if (cur_e || !cur_u || row_r == `CME_ROW_LAST) begin
                     eom_r <= cur_e; // RQ1
                     st_r <= ST_IDLE;
                     done_r <= 1'b1;
                  end else
                     row_r <= row_inc;
               end
            end
            ST_CAP: begin
               if (stop_now) begin
                  if (wrote_r) begin
                     eom_m[row_r - `CME_ROW_ONE] <= 1'b1; // RQ4
                     play_r <= cap_start_r;
                     cap_r <= row_r;
                  end
                  st_r <= ST_IDLE;
                  done_r <= 1'b1;
               end else if (tick) begin
                  used_m[row_r] <= 1'b1;
                  wrote_r <= 1'b1;
                  if (row_r == `CME_ROW_LAST) begin
                     eom_m[row_r] <= 1'b1; // RQ4
                     full_r <= 1'b1;
                     play_r <= cap_start_r;
                     cap_r <= row_r;
                     st_r <= ST_IDLE;
                     done_r <= 1'b1;
                  end else begin
                     eom_m[row_r] <= 1'b0;
                     row_r <= row_inc;
                  end
               end
            end
            ST_ERASE: begin
               used_m[row_r] <= 1'b0; // RQ7
               eom_m[row_r] <= 1'b0;
               row_r <= row_nx;
               if (cur_e || row_r == `CME_ROW_LAST) begin
                  if (play_r == last_start_r)
                     cap_r <= play_r;
                  full_r <= 1'b0;
                  st_r <= ST_IDLE;
                  done_r <= 1'b1;
               end
            end
            ST_WIPE: begin
               used_m[row_r] <= 1'b0; // RQ11
               eom_m[row_r] <= 1'b0;
               row_r <= row_inc;
               if (row_r == `CME_ROW_LAST) begin
                  play_r <= `CME_ROW_FIRST;
                  cap_r <= `CME_ROW_FIRST;
                  full_r <= 1'b0;
                  st_r <= ST_IDLE; // RQ12
                  init_r <= 1'b0;
                  done_r <= ~init_r;
               end
            end
            ST_SKIP: begin
               row_r <= row_nx;
               if (!cur_u) begin
                  st_r <= ST_IDLE;
                  done_r <= 1'b1;
               end else if (cur_e) begin
                  play_r <= row_nx; // RQ13
                  st_r <= ST_IDLE;
                  done_r <= 1'b1;
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end
endmodule

/* cme_exec_asserts.sv */
module cme_exec_asserts (
   // Clock and reset
   input wire        clk_i,
   input wire        rst_i,
   // Bus
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire [7:0]  wb_adr_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   // Link and pins
   input wire        ss_n_i,
   input wire        miso_oe_o,
   input wire        int_n_o,
   input wire        ready_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_ack_answer: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_unmapped_zero: assert property (
      wb_ack_o && wb_adr_i[7:4] != 4'h0 |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_oe_select: assert property ((!ss_n_i) [*4] |-> miso_oe_o)
      else $error("reply not driven in frame");
   a_oe_release: assert property (ss_n_i [*4] |-> !miso_oe_o)
      else $error("reply driven outside frame");
   a_int_when_idle: assert property (
      $fell(int_n_o) |-> ready_o && $past(ready_o))
      else $error("interrupt before idle");
   a_int_release: assert property ($rose(int_n_o) |-> ss_n_i)
      else $error("interrupt released mid frame");
   a_busy_cause: assert property (
      $fell(ready_o) |-> ss_n_i && !miso_oe_o)
      else $error("busy started mid frame");
   a_busy_min: assert property ($fell(ready_o) |=> !ready_o [*8])
      else $error("layout scan too short");
endmodule

bind cme_exec cme_exec_asserts cme_exec_asserts_i (
   .clk_i     (clk_i),
   .rst_i     (rst_i),
   .wb_cyc_i  (wb_cyc_i),
   .wb_stb_i  (wb_stb_i),
   .wb_adr_i  (wb_adr_i),
   .wb_dat_o  (wb_dat_o),
   .wb_ack_o  (wb_ack_o),
   .ss_n_i    (ss_n_i),
   .miso_oe_o (miso_oe_o),
   .int_n_o   (int_n_o),
   .ready_o   (ready_o)
);

/* cme_host_model.sv */
module cme_host_model (
   // Clock
   input  wire  clk_i,
   // Reply line
   input  wire  miso_i,
   // Link outputs
   output logic sclk_o,
   output logic mosi_o,
   output logic ss_n_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      sclk_o = 1'b0;
      mosi_o = 1'b0;
      ss_n_o = 1'b1;
   end
   // Two-byte frame, mode 0, MSB first, 400 ns link clock
   task automatic frame(input logic [7:0] op, output logic [7:0] st);
      logic [15:0] w;
      w = {op, 8'h00};
      @(posedge clk_i);
      ss_n_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      for (int i = 15; i >= 0; i--) begin
         mosi_o <= w[i];
         repeat (4) @(posedge clk_i);
         sclk_o <= 1'b1;
         if (i > 7)
            st[i-8] = miso_i;
         repeat (4) @(posedge clk_i);
         sclk_o <= 1'b0;
      end
      // Released line shows the inverse
      mosi_o <= ~mosi_o;
      repeat (4) @(posedge clk_i);
      ss_n_o <= 1'b1;
      repeat (20) @(posedge clk_i);
   endtask
endmodule

/* cme_exec_tb.sv */
`include "cme_consts.vh"
module cme_exec_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i    = 1'b0;
   logic        rst_i    = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i  = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] c0;
   logic [31:0] c1;
   wire  [31:0] wb_dat_o;
   wire         wb_ack_o, sclk, mosi, ss_n, miso, miso_oe, int_n_o, ready_o;
   wire         miso_w = miso_oe ? miso : 1'bz;
   int          errors = 0;
   int          total_checks = 0;
   always #25 clk_i = ~clk_i;
   cme_exec cme_exec_i (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .sclk_i(sclk), .mosi_i(mosi), .ss_n_i(ss_n),
      .miso_o(miso), .miso_oe_o(miso_oe), .int_n_o(int_n_o),
      .ready_o(ready_o));
   cme_host_model cme_host_model_i (
      .clk_i(clk_i), .miso_i(miso_w), .sclk_o(sclk), .mosi_o(mosi),
      .ss_n_o(ss_n));
   task automatic chk(input string n, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic xfer(input logic [7:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      chk("ack", 32'h1, {31'h0, wb_ack_o});
   endtask
   task automatic sr(output logic [31:0] q);
      xfer(8'h04, 1'b0, 32'h0, q);
   endtask
   task automatic cmd(input logic [7:0] op);
      logic [7:0] s;
      cme_host_model_i.frame(op, s);
   endtask
   task automatic wait_rdy(input int lim);
      int n;
      n = 0;
      while (ready_o !== 1'b1 && n < lim) begin
         @(posedge clk_i);
         n++;
      end
      repeat (2) @(posedge clk_i);
      chk("ready", 32'h1, {31'h0, ready_o});
   endtask
   // Idle status, unmapped place, reply byte, power up
   task automatic t_idle;
      logic [31:0] q;
      logic [7:0]  s;
      sr(q);
      chk("sr1 idle", 32'hF, {28'h0, q[11:8]});
      xfer(8'h40, 1'b0, 32'h0, q);
      chk("unmapped", 32'h0, q);
      sr(q);
      cme_host_model_i.frame(`CME_OP_STAT, s);
      chk("reply", {24'h0, q[7:0]}, {24'h0, s});
      cmd(`CME_OP_CHK);
      sr(q);
      chk("chk asleep", 32'h1, {31'h0, q[0]});
      xfer(8'h00, 1'b1, 32'h01, q);
      xfer(8'h00, 1'b0, 32'h0, q);
      chk("last op", 32'h01, {24'h0, q[7:0]});
      sr(q);
      chk("pu", 32'h1, {31'h0, q[2]});
   endtask
   // Wipe refuses stop, raises irq, irq clear
   task automatic t_wipe;
      logic [31:0] q;
      cmd(`CME_OP_WIPE);
      repeat (2100) @(posedge clk_i);
      sr(q);
      chk("wipe busy", 32'h0, {30'h0, q[9:8]});
      cmd(`CME_OP_STOP);
      sr(q);
      chk("stop flag", 32'h1, {31'h0, q[0]});
      chk("stop held", 32'h0, {31'h0, q[8]});
      wait_rdy(3000);
      chk("irq pin", 32'h0, {31'h0, int_n_o});
      cmd(`CME_OP_IRQC);
      sr(q);
      chk("irq eom", 32'h0, {30'h0, q[4:3]});
      chk("irq pin", 32'h1, {31'h0, int_n_o});
      chk("state", 32'h1, {31'h0, ready_o});
   endtask
   // Capture refuses skip, stops on stop
   task automatic t_cap;
      logic [31:0] q;
      xfer(8'h0C, 1'b0, 32'h0, c0);
      cmd(`CME_OP_CAP);
      repeat (2100) @(posedge clk_i);
      sr(q);
      chk("cap busy", 32'h0, {30'h0, q[11], q[8]});
      cmd(`CME_OP_SKIP);
      sr(q);
      chk("cap flag", 32'h1, {31'h0, q[0]});
      repeat (320) @(posedge clk_i);
      cmd(`CME_OP_STOP);
      wait_rdy(100);
      xfer(8'h0C, 1'b0, 32'h0, c1);
      chk("cap moved", 32'h1, {31'h0, c1 !== c0});
      cmd(`CME_OP_IRQC);
   endtask
   // Layout check sets both pointers
   task automatic t_check;
      logic [31:0] q;
      cmd(`CME_OP_CHK);
      wait_rdy(3000);
      sr(q);
      chk("chk ok", 32'h0, {31'h0, q[0]});
      xfer(8'h08, 1'b0, 32'h0, q);
      chk("playback_pointer", c0, q);
      xfer(8'h0C, 1'b0, 32'h0, q);
      chk("cap ptr", c1, q);
      cmd(`CME_OP_IRQC);
   endtask
   // Playback to end marker, then play, stop, skip
   task automatic t_play;
      logic [31:0] q;
      cmd(`CME_OP_PLAY);
      repeat (2100) @(posedge clk_i);
      sr(q);
      chk("play busy", 32'h0, {30'h0, q[10], q[8]});
      cmd(`CME_OP_SKIP);
      sr(q);
      chk("skip refused", 32'h1, {31'h0, q[0]});
      wait_rdy(2000);
      sr(q);
      chk("eom", 32'h1, {31'h0, q[3]});
      cmd(`CME_OP_IRQC);
      cmd(`CME_OP_PLAY);
      repeat (2100) @(posedge clk_i);
      cmd(`CME_OP_STOP);
      wait_rdy(100);
      cmd(`CME_OP_SKIP);
      wait_rdy(3000);
      sr(q);
      chk("skip ok", 32'h0, {31'h0, q[0]});
      chk("skip irq", 32'h0, {31'h0, int_n_o});
      xfer(8'h08, 1'b0, 32'h0, q);
      chk("skip ptr", c1, q);
      cmd(`CME_OP_IRQC);
   endtask
   // Erase away from a message refused, then erase of the only message
   task automatic t_erase;
      logic [31:0] q;
      cmd(`CME_OP_ERASE);
      wait_rdy(3000);
      sr(q);
      chk("erase refused", 32'h1, {31'h0, q[0]});
      cmd(`CME_OP_CHK);
      wait_rdy(3000);
      xfer(8'h0C, 1'b0, 32'h0, q);
      chk("erase none", c1, q);
      cmd(`CME_OP_ERASE);
      wait_rdy(3000);
      sr(q);
      chk("erase ok", 32'h0, {31'h0, q[0]});
      xfer(8'h0C, 1'b0, 32'h0, q);
      chk("erase ptr", c0, q);
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      #2500000;
      errors++;
      end_of_test();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      wait_rdy(3000);
      t_idle();
      t_wipe();
      t_cap();
      t_check();
      t_play();
      t_erase();
      end_of_test();
   end
endmodule
